// ===== tb/amcal_field_model.sv
`timescale 1ns/1ns
module amcal_field_model (
    input  wire logic       sys_clk,   // Clock
    input  wire logic       rst,       // Async reset, high
    input  wire logic       adc_start, // Conversion request
    input  wire logic       tx_on,     // Transmitter enabled
    input  wire logic [7:0] drv,       // Segment enables
    input  wire logic [3:0] lat,       // Conversion latency
    output logic            adc_done,  // Conversion finished
    output logic      [7:0] adc_data   // Amplitude, valid with done
);
    localparam logic [8:0] FULL_AMP = 9'h0C8;
    logic [3:0] cnt_q;
    logic       run_q;
    logic [7:0] amp_q;
    logic [7:0] last_q;
    logic [8:0] off_w;

    // Every disabled segment lowers the field by its binary weight
    assign off_w = {1'b0, ~drv};

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            run_q  <= 1'b0;
            cnt_q  <= 4'h0;
            amp_q  <= 8'h00;
            last_q <= 8'h00;
        end
        else if (adc_start)
        begin
            run_q <= 1'b1;
            cnt_q <= lat;
            amp_q <= (!tx_on || off_w > FULL_AMP) ? 8'h00 : 8'(FULL_AMP - off_w);
        end
        else if (run_q)
        begin
            if (cnt_q == 4'h0)
            begin
                run_q  <= 1'b0;
                last_q <= amp_q;
            end
            else
                cnt_q <= cnt_q - 4'h1;
        end
    end

    assign adc_done = run_q && (cnt_q == 4'h0);
    // Data lines carry the inverted previous result outside a result
    assign adc_data = adc_done ? amp_q : ~last_q;
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic       sys_clk;
    logic       rst;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       mod_req;
    logic       adc_start;
    logic       adc_done;
    logic [7:0] adc_data;
    logic       tx_on;
    logic [7:0] drv;
    logic [7:0] drv_b;
    logic [3:0] lat;
    int         err_total;
    int         tests_run;
    int         cyc;
    int         nc;
    logic [7:0] rd_v;
    logic [7:0] best;
    logic [7:0] tg;
    logic [5:0] ratios [4] = '{6'h00, 6'h0E, 6'h3F, 6'h20};
    logic [7:0] cands [3]  = '{8'h40, 8'h78, 8'h80};

    amcal_top DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_req(mod_req),
        .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data), .tx_on(tx_on),
        .antenna_driver_outputs(drv), .antenna_driver_outputs_b(drv_b));

    amcal_field_model u_field (.sys_clk(sys_clk), .rst(rst), .adc_start(adc_start),
        .tx_on(tx_on), .drv(drv), .lat(lat), .adc_done(adc_done), .adc_data(adc_data));

    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_v = reg_rdata;
    endtask

    task automatic chkrd(input logic [5:0] a, input logic [7:0] exp);
        rd(a);
        chk(rd_v, exp);
    endtask

    // Driver outputs follow one cycle after their cause
    task automatic chk_drv(input logic [7:0] exp);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(drv, exp);
        chk(drv_b, exp);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        rd(amcal_pkg::ADDR_STATUS);
        while (rd_v[0] !== 1'b0 && n < 2000)
        begin
            rd(amcal_pkg::ADDR_STATUS);
            n++;
        end
        if (n >= 2000)
            err_total++;
    endtask

    task automatic measure;
        wr(amcal_pkg::ADDR_CMD, amcal_pkg::CMD_MEASURE);
        wait_idle();
        rd(amcal_pkg::ADDR_ADC);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_total++;
            complete_run();
        end
    end

    initial
    begin
        rst       = 1'b1;
        reg_addr  = 6'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        mod_req   = 1'b0;
        lat       = 4'h1;
        err_total = 0;
        tests_run = 0;
        cyc       = 0;
        best      = 8'h00;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        chkrd(amcal_pkg::ADDR_TX_CFG, amcal_pkg::RST_TX_CFG);
        chkrd(amcal_pkg::ADDR_DEPTH, amcal_pkg::RST_DEPTH);
        chkrd(amcal_pkg::ADDR_NORMAL, amcal_pkg::RST_NORMAL);
        chkrd(amcal_pkg::ADDR_MODLVL, amcal_pkg::RST_MODLVL);
        wr(amcal_pkg::ADDR_DISPLAY, 8'hFF);
        chkrd(amcal_pkg::ADDR_DISPLAY, 8'h00);
        chkrd(6'h3F, 8'h00);
        chk_drv(8'h00);
        wr(amcal_pkg::ADDR_TX_CFG, 8'h02);
        chk_drv(8'hFF);
        wr(amcal_pkg::ADDR_NORMAL, 8'h0F);
        chk_drv(8'hF0);
        // Host-run search for a depth beyond the automatic range
        wr(amcal_pkg::ADDR_NORMAL, 8'h00);
        measure();
        chk(rd_v, 8'hC8);
        tg = 8'h50;
        for (int i = 0; i < 3; i++)
        begin
            wr(amcal_pkg::ADDR_NORMAL, cands[i]);
            measure();
            chk(rd_v, 8'(200 - int'(cands[i])));
            if (rd_v === tg)
                best = cands[i];
        end
        chk(best, 8'h78);
        wr(amcal_pkg::ADDR_MODLVL, best);
        wr(amcal_pkg::ADDR_NORMAL, 8'h00);
        wr(amcal_pkg::ADDR_DEPTH, 8'h80);
        wr(amcal_pkg::ADDR_TX_CFG, 8'h03);
        mod_req <= 1'b1;
        chk_drv(~best);
        wr(amcal_pkg::ADDR_TX_CFG, 8'h02);
        chk_drv(8'h00);
        chk({7'h00, tx_on}, 8'h00);
        @(posedge sys_clk);
        mod_req <= 1'b0;
        wr(amcal_pkg::ADDR_TX_CFG, 8'h00);
        wr(amcal_pkg::ADDR_CMD, amcal_pkg::CMD_MEASURE);
        repeat (3) @(posedge sys_clk);
        #1;
        chk({7'h00, tx_on}, 8'h01);
        nc = 3;
        while (adc_start !== 1'b1 && nc < 200)
        begin
            @(posedge sys_clk);
            #1;
            nc++;
        end
        chk(8'(nc), 8'(amcal_pkg::SETTLE_CYC - 1));
        wait_idle();
        for (int p = 0; p < 8; p++)
        begin
            wr(amcal_pkg::ADDR_PROTO, 8'(p));
            wr(amcal_pkg::ADDR_TX_CFG, 8'h02);
            wr(amcal_pkg::ADDR_CMD, amcal_pkg::CMD_PRESET);
            rd(amcal_pkg::ADDR_TX_CFG);
            chk({7'h00, rd_v[0]}, (p inside {1, 3, 4, 6, 7}) ? 8'h01 : 8'h00);
        end
        for (int i = 0; i < 4; i++)
        begin
            lat <= i[0] ? 4'hF : 4'h0;
            wr(amcal_pkg::ADDR_NORMAL, 8'h00);
            wr(amcal_pkg::ADDR_DEPTH, {1'b0, ratios[i], 1'b0});
            wr(amcal_pkg::ADDR_CMD, amcal_pkg::CMD_CALIBRATE);
            wait_idle();
            tg = 8'(12800 / (64 + int'(ratios[i])));
            chkrd(amcal_pkg::ADDR_ADC, 8'hC8);
            chkrd(amcal_pkg::ADDR_DISPLAY, 8'(200 - int'(tg)));
            wr(amcal_pkg::ADDR_TX_CFG, 8'h03);
            mod_req <= 1'b1;
            chk_drv(~(8'(200 - int'(tg))));
            @(posedge sys_clk);
            mod_req <= 1'b0;
        end
        complete_run();
    end
endmodule

// ===== verilog/amcal_pkg.sv
package amcal_pkg;
    // Register map, 6-bit addresses
    localparam logic [5:0] ADDR_TX_CFG  = 6'h00;
    localparam logic [5:0] ADDR_PROTO   = 6'h01;
    localparam logic [5:0] ADDR_DEPTH   = 6'h02;
    localparam logic [5:0] ADDR_NORMAL  = 6'h03;
    localparam logic [5:0] ADDR_MODLVL  = 6'h04;
    localparam logic [5:0] ADDR_DISPLAY = 6'h05;
    localparam logic [5:0] ADDR_ADC     = 6'h06;
    localparam logic [5:0] ADDR_CMD     = 6'h07;
    localparam logic [5:0] ADDR_STATUS  = 6'h08;
    // Field positions
    localparam int TX_AM_BIT  = 0;
    localparam int TX_EN_BIT  = 1;
    localparam int SRC_BIT    = 7;
    localparam int RATIO_LSB  = 1;
    localparam int RATIO_MSB  = 6;
    localparam int BUSY_BIT   = 0;
    // Reset values
    localparam logic [7:0] RST_TX_CFG = 8'h00;
    localparam logic [2:0] RST_PROTO  = 3'h0;
    localparam logic [7:0] RST_DEPTH  = 8'h1C;
    localparam logic [7:0] RST_NORMAL = 8'h00;
    localparam logic [7:0] RST_MODLVL = 8'h00;
    // Commands written to ADDR_CMD
    localparam logic [7:0] CMD_CALIBRATE = 8'h01;
    localparam logic [7:0] CMD_MEASURE   = 8'h02;
    localparam logic [7:0] CMD_PRESET    = 8'h03;
    // Protocol codes
    localparam logic [2:0] PROTO_TYPE_A   = 3'h0;
    localparam logic [2:0] PROTO_TYPE_B   = 3'h1;
    localparam logic [2:0] PROTO_VICINITY = 3'h2;
    localparam logic [2:0] PROTO_PROP_212 = 3'h3;
    localparam logic [2:0] PROTO_PROP_424 = 3'h4;
    localparam logic [2:0] PROTO_NFC_106  = 3'h5;
    localparam logic [2:0] PROTO_NFC_212  = 3'h6;
    localparam logic [2:0] PROTO_NFC_424  = 3'h7;
    // Field settling time after a driver change
    localparam int CLK_PERIOD_NS = 8;
    localparam int SETTLE_NS     = 1000;
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETTLE = 3'b001,
        ST_MEAS   = 3'b010,
        ST_TGT    = 3'b011,
        ST_SAR    = 3'b100
    } amcal_state_t;

    typedef enum logic [1:0] {
        SAR_IDLE   = 2'b00,
        SAR_SETTLE = 2'b01,
        SAR_WAIT   = 2'b10
    } amcal_sar_state_t;
endpackage

// ===== verilog/amcal_sar.sv
`timescale 1ns/1ns
module amcal_sar #(
    parameter int SEG_W      = 8,
    parameter int SETTLE_CYC = amcal_pkg::SETTLE_CYC
) (
    input wire logic  sys_clk, // Clock
    input wire logic  rst,     // Async reset
    amcal_sar_if.engine sar    // Search control
);
    if (SEG_W != 8 || SETTLE_CYC < 1 || SETTLE_CYC > 65535)
    begin : g_chk
        $error("amcal_sar: unsupported parameters");
    end

    amcal_pkg::amcal_sar_state_t st_q;
    logic [7:0]  trial_q;
    logic [2:0]  bit_q;
    logic [15:0] cnt_q;
    logic        keep;

    assign keep          = sar.adc_data >= sar.target;
    assign sar.code      = trial_q;
    assign sar.busy      = st_q != amcal_pkg::SAR_IDLE;
    assign sar.adc_start = st_q == amcal_pkg::SAR_SETTLE && cnt_q == 16'(SETTLE_CYC - 1);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q       <= amcal_pkg::SAR_IDLE;
            trial_q    <= 8'h00;
            bit_q      <= 3'h7;
            cnt_q      <= 16'h0000;
            sar.done   <= 1'b0;
            sar.result <= 8'h00;
        end
        else
        begin
            sar.done <= 1'b0;
            case (st_q)
                amcal_pkg::SAR_IDLE:
                    if (sar.start)
                    begin
                        trial_q <= 8'h80;
                        bit_q   <= 3'h7;
                        cnt_q   <= 16'h0000;
                        st_q    <= amcal_pkg::SAR_SETTLE;
                    end
                amcal_pkg::SAR_SETTLE:
                    if (sar.adc_start)
                        st_q <= amcal_pkg::SAR_WAIT;
                    else
                        cnt_q <= cnt_q + 16'h0001;
                amcal_pkg::SAR_WAIT:
                    if (sar.adc_done)
                    begin
                        if (bit_q == 3'h0)
                        begin
                            sar.result <= {trial_q[7:1], keep};
                            sar.done   <= 1'b1;
                            st_q       <= amcal_pkg::SAR_IDLE;
                        end
                        else
                        begin
                            trial_q[bit_q]        <= keep;
                            trial_q[bit_q - 3'h1] <= 1'b1;
                            bit_q                 <= bit_q - 3'h1;
                            cnt_q                 <= 16'h0000;
                            st_q                  <= amcal_pkg::SAR_SETTLE;
                        end
                    end
                default:
                    st_q <= amcal_pkg::SAR_IDLE;
            endcase
        end
    end

    property p_sar_msb;
        @(posedge sys_clk) disable iff (rst)
        (st_q == amcal_pkg::SAR_IDLE && sar.start) |=> sar.code == 8'h80 ##1 sar.busy;
    endproperty
    a_sar_msb: assert property (p_sar_msb) else $error("search not MSB first");

    property p_sar_keep;
        @(posedge sys_clk) disable iff (rst)
        (st_q == amcal_pkg::SAR_WAIT && sar.adc_done && bit_q != 3'h0)
            |=> sar.code[$past(bit_q)] == $past(keep) && sar.code[$past(bit_q) - 3'h1];
    endproperty
    a_sar_keep: assert property (p_sar_keep) else $error("search step wrong");
endmodule

// ===== verilog/amcal_sar_if.sv
`timescale 1ns/1ns
interface amcal_sar_if;
    logic       start;
    logic [7:0] target;
    logic       adc_done;
    logic [7:0] adc_data;
    logic       busy;
    logic       done;
    logic [7:0] code;
    logic [7:0] result;
    logic       adc_start;
    modport ctrl (output start, target, adc_done, adc_data,
                  input busy, done, code, result, adc_start);
    modport engine (input start, target, adc_done, adc_data,
                    output busy, done, code, result, adc_start);
endinterface

// ===== verilog/amcal_target.sv
`timescale 1ns/1ns
module amcal_target (
    input  wire logic       sys_clk,  // Clock
    input  wire logic       rst,      // Async reset
    input  wire logic       load,     // Fresh carrier amplitude
    input  wire logic [7:0] amp,      // Carrier amplitude
    input  wire logic [5:0] ratio,    // Depth ratio code
    output logic      [7:0] target    // Target modulated level
);
    // amp / 1.ratio, done as amp*64 / (64 + ratio)
    function automatic logic [7:0] div_ratio(input logic [7:0] a, input logic [5:0] r);
        logic [13:0] num;
        logic [13:0] den;
        logic [13:0] quo;
        num = {a, 6'h00};
        den = {7'h00, 1'b1, r};
        quo = num / den;
        return quo[7:0];
    endfunction

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            target <= 8'h00;
        else if (load)
            target <= div_ratio(amp, ratio);
    end

    property p_target_bound;
        @(posedge sys_clk) disable iff (rst)
        load |=> (target <= $past(amp)) && ($past(ratio) != 6'h00 || target == $past(amp));
    endproperty
    a_target_bound: assert property (p_target_bound) else $error("target level wrong");
endmodule

// ===== verilog/amcal_top.sv
`timescale 1ns/1ns
//Contract
// - Config bit chooses on-off keying or amplitude modulation.
// - Analog preset picks AM for type B, proprietary 212/424, NFC 212/424.
// - Source bit 0: modulated level comes from calibration result.
// - Ratio code in depth bits 6..1 sets target depth.
// - Target equals stored 8-bit carrier amplitude divided by 1.code.
// - Codes map monotonically from 0% to 33% modulation index.
// - Depth made by disabling binary-weighted driver segments; all on normally.
// - Normal-level register can raise unmodulated driver resistance.
// - Calibrate: enable carrier, measure amplitude, store it, derive target.
// - Successive approximation brings field closest to target.
// - Final setting goes to display register and drives modulated level.
// - Source bit 1: modulated level from host-written register.
module amcal_top (
    input  wire logic       sys_clk,                 // 125 MHz clock
    input  wire logic       rst,                     // Async reset, high
    input  wire logic [5:0] reg_addr,                // Register address
    input  wire logic [7:0] reg_wdata,               // Write data
    input  wire logic       reg_wr,                  // Write strobe
    input  wire logic       reg_rd,                  // Read strobe
    output logic      [7:0] reg_rdata,               // Read data, next cycle
    input  wire logic       mod_req,                 // Modulator on
    output logic            adc_start,               // Start amplitude conversion
    input  wire logic       adc_done,                // Conversion finished
    input  wire logic [7:0] adc_data,                // Sensed carrier amplitude
    output logic            tx_on,                   // Transmitter enabled
    output logic      [7:0] antenna_driver_outputs,  // Segment enables
    output logic      [7:0] antenna_driver_outputs_b // Segment enables, other leg
);
    amcal_pkg::amcal_state_t st_q;
    logic [7:0]  tx_cfg_q;
    logic [2:0]  proto_q;
    logic [7:0]  depth_q;
    logic [7:0]  normal_q;
    logic [7:0]  modlvl_q;
    logic [7:0]  display_q;
    logic [7:0]  adc_q;
    logic        cal_q;
    logic [15:0] cnt_q;
    logic        own_start;
    logic        cmd_wr;
    logic        busy;
    logic [7:0]  target;
    logic [7:0]  code_d;
    logic        on_d;
    logic        am_sel;
    logic        src_sel;
    logic        preset_am;

    amcal_sar_if sar_bus ();

    assign busy      = st_q != amcal_pkg::ST_IDLE;
    assign cmd_wr    = reg_wr && reg_addr == amcal_pkg::ADDR_CMD && !busy;
    assign am_sel    = tx_cfg_q[amcal_pkg::TX_AM_BIT];
    assign src_sel   = depth_q[amcal_pkg::SRC_BIT];
    assign own_start = st_q == amcal_pkg::ST_SETTLE
                       && cnt_q == 16'(amcal_pkg::SETTLE_CYC - 1);
    assign adc_start = own_start || sar_bus.adc_start;

    assign sar_bus.start    = st_q == amcal_pkg::ST_TGT;
    assign sar_bus.target   = target;
    assign sar_bus.adc_done = adc_done && st_q == amcal_pkg::ST_SAR;
    assign sar_bus.adc_data = adc_data;

    always_comb
    begin
        case (proto_q)
            amcal_pkg::PROTO_TYPE_B,
            amcal_pkg::PROTO_PROP_212,
            amcal_pkg::PROTO_PROP_424,
            amcal_pkg::PROTO_NFC_212,
            amcal_pkg::PROTO_NFC_424: preset_am = 1'b1;
            default:                  preset_am = 1'b0;
        endcase
    end

    amcal_target u_target (
        .sys_clk (sys_clk),
        .rst     (rst),
        .load    (st_q == amcal_pkg::ST_MEAS && adc_done && cal_q),
        .amp     (adc_data),
        .ratio   (depth_q[amcal_pkg::RATIO_MSB:amcal_pkg::RATIO_LSB]),
        .target  (target)
    );

    amcal_sar u_sar (
        .sys_clk (sys_clk),
        .rst     (rst),
        .sar     (sar_bus)
    );

    // Configuration registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_cfg_q <= amcal_pkg::RST_TX_CFG;
            proto_q  <= amcal_pkg::RST_PROTO;
            depth_q  <= amcal_pkg::RST_DEPTH;
            normal_q <= amcal_pkg::RST_NORMAL;
            modlvl_q <= amcal_pkg::RST_MODLVL;
        end
        else
        begin
            if (reg_wr && reg_addr == amcal_pkg::ADDR_TX_CFG)
                tx_cfg_q <= {6'h00, reg_wdata[1:0]};
            if (cmd_wr && reg_wdata == amcal_pkg::CMD_PRESET)
                tx_cfg_q[amcal_pkg::TX_AM_BIT] <= preset_am;
            if (reg_wr && reg_addr == amcal_pkg::ADDR_PROTO)
                proto_q <= reg_wdata[2:0];
            if (reg_wr && reg_addr == amcal_pkg::ADDR_DEPTH)
                depth_q <= {reg_wdata[7:1], 1'b0};
            if (reg_wr && reg_addr == amcal_pkg::ADDR_NORMAL)
                normal_q <= reg_wdata;
            if (reg_wr && reg_addr == amcal_pkg::ADDR_MODLVL)
                modlvl_q <= reg_wdata;
        end
    end

    // Command sequencer
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q  <= amcal_pkg::ST_IDLE;
            cal_q <= 1'b0;
            cnt_q <= 16'h0000;
        end
        else
        begin
            case (st_q)
                amcal_pkg::ST_IDLE:
                    if (cmd_wr && (reg_wdata == amcal_pkg::CMD_CALIBRATE
                                   || reg_wdata == amcal_pkg::CMD_MEASURE))
                    begin
                        cal_q <= reg_wdata == amcal_pkg::CMD_CALIBRATE;
                        cnt_q <= 16'h0000;
                        st_q  <= amcal_pkg::ST_SETTLE;
                    end
                amcal_pkg::ST_SETTLE:
                    if (own_start)
                        st_q <= amcal_pkg::ST_MEAS;
                    else
                        cnt_q <= cnt_q + 16'h0001;
                amcal_pkg::ST_MEAS:
                    if (adc_done)
                        st_q <= cal_q ? amcal_pkg::ST_TGT : amcal_pkg::ST_IDLE;
                amcal_pkg::ST_TGT:
                    st_q <= amcal_pkg::ST_SAR;
                amcal_pkg::ST_SAR:
                    if (sar_bus.done)
                        st_q <= amcal_pkg::ST_IDLE;
                default:
                    st_q <= amcal_pkg::ST_IDLE;
            endcase
        end
    end

    // Measurement and result registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            adc_q     <= 8'h00;
            display_q <= 8'h00;
        end
        else
        begin
            if (st_q == amcal_pkg::ST_MEAS && adc_done)
                adc_q <= adc_data;
            if (st_q == amcal_pkg::ST_SAR && sar_bus.done)
                display_q <= sar_bus.result;
        end
    end

    // Driver level selection; a set code bit turns its segment off
    always_comb
    begin
        code_d = normal_q;
        on_d   = tx_cfg_q[amcal_pkg::TX_EN_BIT];
        case (st_q)
            amcal_pkg::ST_IDLE:
                if (mod_req)
                begin
                    if (!am_sel)
                        on_d = 1'b0;
                    else if (src_sel)
                        code_d = modlvl_q;
                    else
                        code_d = display_q;
                end
            amcal_pkg::ST_SAR:
            begin
                on_d   = 1'b1;
                code_d = sar_bus.code;
            end
            default:
                on_d = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_on                    <= 1'b0;
            antenna_driver_outputs   <= 8'h00;
            antenna_driver_outputs_b <= 8'h00;
        end
        else
        begin
            tx_on                    <= on_d;
            antenna_driver_outputs   <= on_d ? ~code_d : 8'h00;
            antenna_driver_outputs_b <= on_d ? ~code_d : 8'h00;
        end
    end

    // Register read port
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (!reg_rd)
            reg_rdata <= 8'h00;
        else
        begin
            case (reg_addr)
                amcal_pkg::ADDR_TX_CFG:  reg_rdata <= tx_cfg_q;
                amcal_pkg::ADDR_PROTO:   reg_rdata <= {5'h00, proto_q};
                amcal_pkg::ADDR_DEPTH:   reg_rdata <= depth_q;
                amcal_pkg::ADDR_NORMAL:  reg_rdata <= normal_q;
                amcal_pkg::ADDR_MODLVL:  reg_rdata <= modlvl_q;
                amcal_pkg::ADDR_DISPLAY: reg_rdata <= display_q;
                amcal_pkg::ADDR_ADC:     reg_rdata <= adc_q;
                amcal_pkg::ADDR_STATUS:  reg_rdata <= {7'h00, busy};
                default:                 reg_rdata <= 8'h00;
            endcase
        end
    end

    property p_ook_off;
        @(posedge sys_clk) disable iff (rst)
        (st_q == amcal_pkg::ST_IDLE && mod_req && !am_sel)
            |=> !tx_on && antenna_driver_outputs == 8'h00;
    endproperty
    a_ook_off: assert property (p_ook_off) else $error("keying did not cut carrier");

    property p_preset;
        @(posedge sys_clk) disable iff (rst)
        (cmd_wr && reg_wdata == amcal_pkg::CMD_PRESET)
            |=> tx_cfg_q[amcal_pkg::TX_AM_BIT] == $past(preset_am);
    endproperty
    a_preset: assert property (p_preset) else $error("preset chose wrong modulation");

    property p_src_cal;
        @(posedge sys_clk) disable iff (rst)
        (st_q == amcal_pkg::ST_IDLE && mod_req && am_sel && !src_sel && on_d)
            |=> antenna_driver_outputs == ~$past(display_q);
    endproperty
    a_src_cal: assert property (p_src_cal) else $error("calibrated level not used");

    property p_src_host;
        @(posedge sys_clk) disable iff (rst)
        (st_q == amcal_pkg::ST_IDLE && mod_req && am_sel && src_sel && on_d)
            |=> antenna_driver_outputs == ~$past(modlvl_q);
    endproperty
    a_src_host: assert property (p_src_host) else $error("host level not used");

    property p_normal;
        @(posedge sys_clk) disable iff (rst)
        (st_q == amcal_pkg::ST_IDLE && !mod_req && on_d)
            |=> antenna_driver_outputs == ~$past(normal_q) && tx_on;
    endproperty
    a_normal: assert property (p_normal) else $error("normal level wrong");

    property p_cal_meas;
        @(posedge sys_clk) disable iff (rst)
        (st_q == amcal_pkg::ST_MEAS && adc_done && cal_q)
            |=> adc_q == $past(adc_data) ##1 sar_bus.busy && tx_on;
    endproperty
    a_cal_meas: assert property (p_cal_meas) else $error("measure step wrong");

    property p_display;
        @(posedge sys_clk) disable iff (rst)
        (st_q == amcal_pkg::ST_SAR && sar_bus.done)
            |=> display_q == $past(sar_bus.result) && st_q == amcal_pkg::ST_IDLE;
    endproperty
    a_display: assert property (p_display) else $error("result not stored");
endmodule
